// [dgsr_top.v]
// dgsr_top.v: general control/status registers and indexed sequencer registers of a display controller
// assumes one clock CLK; video timing and attribute inputs come from logic on CLK; MON_SENSE is a pin
//
// Overview of operation
// - hardware reset clears the whole general output control register.
// - general output bit 0 picks the io base, 3Bx mono or 3Dx colour.
// - cpu video memory access is allowed only while the access enable bit is 1.
// - clock bits pick 25.175 MHz, 28.322 MHz, reserved, or the extended dot-clock field.
// - page select maps cpu accesses to the low or high 64K page.
// - bits 6 and 7 make horizontal and vertical sync negative when set.
// - vsync gating select outputs vsync ORed with vertical display enable.
// - input status 0 bit 7 reads 0 during vertical retrace, 1 otherwise.
// - status 1 bit 0 shows any retrace, bit 3 shows vertical retrace.
// - two status 1 test bits return two attribute colour outputs chosen by plane enable.
// - sequencer index is 3 bits selecting five registers; upper bits read zero.
// - writing 0 to either reset bit holds the system in reset; 1 releases.
// - bit 0 picks 9 or 8 dot characters; bit 3 halves the dot clock.
// - serializers load every, every other, or every fourth character clock.
// - the screen off bit turns the screen off when 1.
// - each plane write enable bit permits or suppresses cpu writes to its plane.
// - attribute bit 3 picks font B or font A code; code picks 8K region.
// - font select clears during system reset; without extended memory only codes 0, 4.
// - extended memory bit limits cpu access to 16/32K or allows 256K.
// - odd/even addressing sends even addresses to planes 0,2 and odd to 1,3.
// - chain-4 uses the two low cpu address bits to select one plane.
`include "dgsr_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module dgsr_top
(
	input  wire       CLK,
	input  wire       RST_N,
	input  wire [9:0] IO_ADDR,
	input  wire       IO_WR,
	input  wire       IO_RD,
	input  wire [7:0] IO_WDATA,
	output reg  [7:0] IO_RDATA,
	output reg        IO_RVALID,
	input  wire       HSYNC_RAW,
	input  wire       VSYNC_RAW,
	input  wire       HRETRACE,
	input  wire       VRETRACE,
	input  wire       VDISP_EN,
	input  wire       MON_SENSE,
	input  wire [7:0] ATTR_COLOUR,
	input  wire [1:0] ATTR_FEEDBACK_SEL,
	input  wire       ATTR_BIT3,
	input  wire       CPU_WRITE,
	input  wire       CPU_ODD,
	input  wire [1:0] CPU_ADDR_LOW,
	output reg        IO_BASE_COLOUR,
	output reg        CPU_VRAM_ENABLE,
	output reg  [1:0] VCLK_SOURCE,
	output reg        VCLK_USE_EXTENDED,
	output reg        PAGE_HIGH,
	output reg        HSYNC_OUT,
	output reg        VSYNC_OUT,
	output reg        SEQ_RESET,
	output reg        CHAR_8DOT,
	output reg        DOT_CLK_HALF,
	output reg  [1:0] SERIAL_LOAD_RATE,
	output reg        SCREEN_OFF,
	output reg  [2:0] FONT_REGION,
	output reg        CPU_MEM_FULL,
	output reg  [3:0] PLANE_WRITE_MASK
);

	// ****************************************
	// state
	// ****************************************
	reg  [7:0] general_output;
	reg  [7:0] feature_ctrl;
	reg  [2:0] sequencer_index;
	reg  [7:0] seq_reset_ctrl;
	reg  [7:0] clocking_mode;
	reg  [7:0] plane_write_enable;
	reg  [7:0] font_select;
	reg  [7:0] mem_mode;
	reg        mon_meta;
	reg        mon_sync;
	reg  [7:0] next_rdata;
	reg        next_hit;
	reg  [3:0] next_plane_mask;

	wire [9:0] io_base;
	wire       hit_goc_w;
	wire       hit_index;
	wire       hit_data;
	wire       hit_feat_r;
	wire       hit_goc_r;
	wire       hit_feat_stat1;
	wire       vsync_sel;
	wire [7:0] status_zero;
	wire [7:0] status_one;
	wire [1:0] feedback_bits;
	wire [2:0] font_pick;
	wire [2:0] next_font_code;

	// ****************************************
	// helpers
	// ****************************************
	// font code bits {hi, mid, lo} to 8K region order
	function [2:0] font_region_of;
		input [2:0] code;
		begin
			font_region_of = {code[1:0], code[2]};
		end
	endfunction

	// one-hot plane from two bits
	function [3:0] plane_onehot;
		input [1:0] sel;
		begin
			plane_onehot = 4'h1 << sel;
		end
	endfunction

	// ****************************************
	// address decode
	// ****************************************
	assign io_base = general_output[`DGSR_GOC_IOBASE] ? `DGSR_BASE_COLOUR : `DGSR_BASE_MONO;

	assign hit_goc_w      = (IO_ADDR == `DGSR_ADDR_GOC_W);
	assign hit_index      = (IO_ADDR == `DGSR_ADDR_SEQ_INDEX);
	assign hit_data       = (IO_ADDR == `DGSR_ADDR_SEQUENCER_DATA_PORT);
	assign hit_feat_r     = (IO_ADDR == `DGSR_ADDR_FEAT_R);
	assign hit_goc_r      = (IO_ADDR == `DGSR_ADDR_GOC_R);
	assign hit_feat_stat1 = (IO_ADDR == (io_base + `DGSR_OFS_FEAT_STAT1));

	// ****************************************
	// pin synchroniser
	// ****************************************
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			mon_meta <= 1'b0;
			mon_sync <= 1'b0;
		end
		else
		begin
			mon_meta <= MON_SENSE;
			mon_sync <= mon_meta;
		end
	end

	// ****************************************
	// register writes
	// ****************************************
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			general_output     <= `DGSR_RESET_VALUE;
			feature_ctrl       <= `DGSR_RESET_VALUE;
			sequencer_index    <= 3'h0;
			seq_reset_ctrl     <= `DGSR_RESET_VALUE;
			clocking_mode      <= `DGSR_RESET_VALUE;
			plane_write_enable <= `DGSR_RESET_VALUE;
			font_select        <= `DGSR_RESET_VALUE;
			mem_mode           <= `DGSR_RESET_VALUE;
		end
		else
		begin
			if (IO_WR && hit_goc_w)
			begin
				general_output <= IO_WDATA & `DGSR_MASK_GOC;
			end
			if (IO_WR && hit_feat_stat1)
			begin
				feature_ctrl <= IO_WDATA & `DGSR_MASK_FEAT;
			end
			if (IO_WR && hit_index)
			begin
				sequencer_index <= IO_WDATA[2:0];
			end
			// data port goes to the register the index selects
			if (IO_WR && hit_data)
			begin
				case (sequencer_index)
					`DGSR_SR_RESET:
					begin
						seq_reset_ctrl <= IO_WDATA & `DGSR_MASK_RSTCTL;
					end
					`DGSR_SR_CLOCKING:
					begin
						clocking_mode <= IO_WDATA & `DGSR_MASK_CLKMODE;
					end
					`DGSR_SR_PLANE_WE:
					begin
						plane_write_enable <= IO_WDATA & `DGSR_MASK_PLANE;
					end
					`DGSR_SR_FONT:
					begin
						font_select <= IO_WDATA & `DGSR_MASK_FONT;
					end
					`DGSR_SR_MEMMODE:
					begin
						mem_mode <= IO_WDATA & `DGSR_MASK_MEMMODE;
					end
					default:
					begin
						mem_mode <= mem_mode;
					end
				endcase
			end
			// font select also clears while the system is held in reset
			if (!seq_reset_ctrl[`DGSR_RST_ASYNC] || !seq_reset_ctrl[`DGSR_RST_SYNC])
			begin
				font_select <= `DGSR_RESET_VALUE;
			end
		end
	end

	// ****************************************
	// status and read mux
	// ****************************************
	assign status_zero = {~VRETRACE, 2'b00, mon_sync, 4'h0};

	assign feedback_bits = (ATTR_FEEDBACK_SEL == 2'h0) ? {ATTR_COLOUR[2], ATTR_COLOUR[0]}
		: (ATTR_FEEDBACK_SEL == 2'h1) ? {ATTR_COLOUR[5], ATTR_COLOUR[4]}
		: (ATTR_FEEDBACK_SEL == 2'h2) ? {ATTR_COLOUR[3], ATTR_COLOUR[1]}
		: {ATTR_COLOUR[7], ATTR_COLOUR[6]};

	// light pen flag not implemented, reads 0
	assign status_one = `DGSR_STAT1_FIXED
		| {2'b00, feedback_bits, VRETRACE, 2'b00, (HRETRACE | VRETRACE)};

	always @*
	begin
		next_rdata = 8'h00;
		next_hit   = 1'b1;
		if (hit_goc_w)
		begin
			next_rdata = status_zero;
		end
		else if (hit_index)
		begin
			next_rdata = {5'h00, sequencer_index};
		end
		else if (hit_data)
		begin
			case (sequencer_index)
				`DGSR_SR_RESET:
				begin
					next_rdata = seq_reset_ctrl;
				end
				`DGSR_SR_CLOCKING:
				begin
					next_rdata = clocking_mode;
				end
				`DGSR_SR_PLANE_WE:
				begin
					next_rdata = plane_write_enable;
				end
				`DGSR_SR_FONT:
				begin
					next_rdata = font_select;
				end
				`DGSR_SR_MEMMODE:
				begin
					next_rdata = mem_mode;
				end
				default:
				begin
					next_rdata = 8'h00;
				end
			endcase
		end
		else if (hit_feat_r)
		begin
			next_rdata = feature_ctrl;
		end
		else if (hit_goc_r)
		begin
			next_rdata = general_output;
		end
		else if (hit_feat_stat1)
		begin
			next_rdata = status_one;
		end
		else
		begin
			next_hit = 1'b0;
		end
	end

	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			IO_RDATA  <= 8'h00;
			IO_RVALID <= 1'b0;
		end
		else
		begin
			IO_RDATA  <= IO_RD ? next_rdata : 8'h00;
			IO_RVALID <= IO_RD & next_hit;
		end
	end

	// ****************************************
	// cpu plane steering and font choice
	// ****************************************
	always @*
	begin
		next_plane_mask = 4'h0;
		if (mem_mode[`DGSR_MEM_CHN4])
		begin
			next_plane_mask = plane_onehot(CPU_ADDR_LOW);
		end
		else if (!mem_mode[`DGSR_MEM_SEQ])
		begin
			next_plane_mask = CPU_ODD ? 4'hA : 4'h5;
		end
		else
		begin
			next_plane_mask = 4'hF;
		end
		next_plane_mask = next_plane_mask & plane_write_enable[3:0];
		if (!CPU_WRITE || !general_output[`DGSR_GOC_RAMEN])
		begin
			next_plane_mask = 4'h0;
		end
	end

	assign font_pick      = ATTR_BIT3 ? {font_select[4], font_select[1:0]}
		: {font_select[5], font_select[3:2]};
	assign next_font_code = mem_mode[`DGSR_MEM_EXT] ? font_pick : {font_pick[2], 2'b00};

	// ****************************************
	// control outputs
	// ****************************************
	assign vsync_sel = feature_ctrl[`DGSR_FEAT_VGATE] ? (VSYNC_RAW | VDISP_EN) : VSYNC_RAW;

	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			IO_BASE_COLOUR    <= 1'b0;
			CPU_VRAM_ENABLE   <= 1'b0;
			VCLK_SOURCE       <= `DGSR_CLKSRC_25;
			VCLK_USE_EXTENDED <= 1'b0;
			PAGE_HIGH         <= 1'b0;
			HSYNC_OUT         <= 1'b0;
			VSYNC_OUT         <= 1'b0;
			SEQ_RESET         <= 1'b1;
			CHAR_8DOT         <= 1'b0;
			DOT_CLK_HALF      <= 1'b0;
			SERIAL_LOAD_RATE  <= `DGSR_LOAD_EVERY;
			SCREEN_OFF        <= 1'b0;
			FONT_REGION       <= 3'h0;
			CPU_MEM_FULL      <= 1'b0;
			PLANE_WRITE_MASK  <= 4'h0;
		end
		else
		begin
			IO_BASE_COLOUR    <= general_output[`DGSR_GOC_IOBASE];
			CPU_VRAM_ENABLE   <= general_output[`DGSR_GOC_RAMEN];
			VCLK_SOURCE       <= general_output[`DGSR_GOC_CLK_HI:`DGSR_GOC_CLK_LO];
			VCLK_USE_EXTENDED <= (general_output[`DGSR_GOC_CLK_HI:`DGSR_GOC_CLK_LO] == `DGSR_CLKSRC_EXT);
			PAGE_HIGH         <= general_output[`DGSR_GOC_PAGE];
			HSYNC_OUT         <= HSYNC_RAW ^ general_output[`DGSR_GOC_HNEG];
			VSYNC_OUT         <= vsync_sel ^ general_output[`DGSR_GOC_VNEG];
			SEQ_RESET         <= ~(seq_reset_ctrl[`DGSR_RST_ASYNC] & seq_reset_ctrl[`DGSR_RST_SYNC]);
			CHAR_8DOT         <= clocking_mode[`DGSR_CLK_8DOT];
			DOT_CLK_HALF      <= clocking_mode[`DGSR_CLK_HALVE];
			SERIAL_LOAD_RATE  <= clocking_mode[`DGSR_CLK_LOAD4] ? `DGSR_LOAD_QUARTER
				: (clocking_mode[`DGSR_CLK_LOAD2] ? `DGSR_LOAD_HALF : `DGSR_LOAD_EVERY);
			SCREEN_OFF        <= clocking_mode[`DGSR_CLK_BLANK];
			FONT_REGION       <= font_region_of(next_font_code);
			CPU_MEM_FULL      <= mem_mode[`DGSR_MEM_EXT];
			PLANE_WRITE_MASK  <= next_plane_mask;
		end
	end

endmodule

`default_nettype wire

// [dgsr_consts.vh]
// dgsr_consts.vh: offsets, field positions and reset values of the general and sequencer register bank
// assumes inclusion by dgsr_top.v only; definitions only
`ifndef DGSR_CONSTS_VH
`define DGSR_CONSTS_VH

// ****************************************
// io port addresses
// ****************************************
`define DGSR_ADDR_GOC_W       10'h3C2
`define DGSR_ADDR_STATUS0     10'h3C2
`define DGSR_ADDR_SEQ_INDEX   10'h3C4
`define DGSR_ADDR_SEQUENCER_DATA_PORT    10'h3C5
`define DGSR_ADDR_FEAT_R      10'h3CA
`define DGSR_ADDR_GOC_R       10'h3CC
`define DGSR_BASE_MONO        10'h3B0
`define DGSR_BASE_COLOUR      10'h3D0
`define DGSR_OFS_FEAT_STAT1   10'h00A

// ****************************************
// sequencer indices
// ****************************************
`define DGSR_SR_RESET         3'h0
`define DGSR_SR_CLOCKING      3'h1
`define DGSR_SR_PLANE_WE      3'h2
`define DGSR_SR_FONT          3'h3
`define DGSR_SR_MEMMODE       3'h4

// ****************************************
// field positions
// ****************************************
`define DGSR_GOC_IOBASE       0
`define DGSR_GOC_RAMEN        1
`define DGSR_GOC_CLK_LO       2
`define DGSR_GOC_CLK_HI       3
`define DGSR_GOC_PAGE         5
`define DGSR_GOC_HNEG         6
`define DGSR_GOC_VNEG         7
`define DGSR_FEAT_VGATE       3
`define DGSR_RST_ASYNC        0
`define DGSR_RST_SYNC         1
`define DGSR_CLK_8DOT         0
`define DGSR_CLK_LOAD2        2
`define DGSR_CLK_HALVE        3
`define DGSR_CLK_LOAD4        4
`define DGSR_CLK_BLANK        5
`define DGSR_MEM_EXT          1
`define DGSR_MEM_SEQ          2
`define DGSR_MEM_CHN4         3

// ****************************************
// writable masks and reset values
// ****************************************
`define DGSR_MASK_GOC         8'hEF
`define DGSR_MASK_FEAT        8'h08
`define DGSR_MASK_RSTCTL      8'h03
`define DGSR_MASK_CLKMODE     8'h3D
`define DGSR_MASK_PLANE       8'h0F
`define DGSR_MASK_FONT        8'h3F
`define DGSR_MASK_MEMMODE     8'h0E
`define DGSR_RESET_VALUE      8'h00
`define DGSR_STAT1_FIXED      8'h04

// ****************************************
// clock source codes and load rates
// ****************************************
`define DGSR_CLKSRC_25        2'h0
`define DGSR_CLKSRC_28        2'h1
`define DGSR_CLKSRC_RSVD      2'h2
`define DGSR_CLKSRC_EXT       2'h3
`define DGSR_LOAD_EVERY       2'h0
`define DGSR_LOAD_HALF        2'h1
`define DGSR_LOAD_QUARTER     2'h2

`endif

// [dgsr_top_props.sv]
// dgsr_top_props.sv: port-level assertions for the general and sequencer register bank
// assumes one clock CLK and asynchronous active-low RST_N; bound into dgsr_top
`timescale 1ns/1ps
`default_nettype none
module dgsr_checker
(
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic [9:0] IO_ADDR,
	input wire logic       IO_WR,
	input wire logic       IO_RD,
	input wire logic [7:0] IO_WDATA,
	input wire logic [7:0] IO_RDATA,
	input wire logic       IO_RVALID,
	input wire logic       HRETRACE,
	input wire logic       VRETRACE,
	input wire logic       CPU_WRITE,
	input wire logic       CPU_VRAM_ENABLE,
	input wire logic       IO_BASE_COLOUR,
	input wire logic       VCLK_USE_EXTENDED,
	input wire logic       SEQ_RESET,
	input wire logic [2:0] FONT_REGION,
	input wire logic       CPU_MEM_FULL,
	input wire logic [3:0] PLANE_WRITE_MASK
);
default clocking cb @(posedge CLK); endclocking
default disable iff (!RST_N);
// ****************************************
// assertions
// ****************************************
sequence gen_wr;
	IO_WR && IO_ADDR == 10'h3C2 ##1 !(IO_WR && IO_ADDR == 10'h3C2);
endsequence
AST_IO_BASE: assert property (gen_wr |-> ##1 IO_BASE_COLOUR == $past(IO_WDATA[0], 2))
	else $error("io base select does not follow write");
AST_VCLK_EXT: assert property (gen_wr |-> ##1 VCLK_USE_EXTENDED == &$past(IO_WDATA[3:2], 2))
	else $error("extended clock flag does not follow write");
AST_STATUS0: assert property (IO_RD && IO_ADDR == 10'h3C2 |=> IO_RVALID && IO_RDATA[7] == !$past(VRETRACE)
	&& IO_RDATA[6:5] == 2'h0 && IO_RDATA[3:0] == 4'h0)
	else $error("status zero read wrong");
AST_STATUS1: assert property (IO_RD && IO_ADDR[3:0] == 4'hA && IO_ADDR[7:4] != 4'hC ##1 IO_RVALID
	|-> IO_RDATA[3:0] == {$past(VRETRACE), 2'b10, $past(HRETRACE) | $past(VRETRACE)})
	else $error("status one retrace bits wrong");
AST_SEQ_INDEX: assert property (IO_RD && IO_ADDR == 10'h3C4 |=> IO_RVALID && IO_RDATA[7:3] == 5'h00)
	else $error("sequencer index upper bits not zero");
AST_UNMAPPED: assert property (IO_RD && IO_ADDR == 10'h3C0 |=> !IO_RVALID && IO_RDATA == 8'h00)
	else $error("unmapped read answered");
AST_SEQ_RESET: assert property ($fell(SEQ_RESET) |-> $past(IO_WR, 2) && $past(IO_ADDR, 2) == 10'h3C5)
	else $error("sequencer reset released without data write");
AST_PLANE_GATE: assert property (PLANE_WRITE_MASK != 4'h0 |-> $past(CPU_WRITE) && CPU_VRAM_ENABLE)
	else $error("plane mask without cpu write");
AST_FONT_LIMIT: assert property (!CPU_MEM_FULL [*3] |-> FONT_REGION[2:1] == 2'h0)
	else $error("font region beyond codes 0 and 4");
C_GEN_WR: cover property (gen_wr);
C_SEQ_REL: cover property ($fell(SEQ_RESET));
C_ALL_PLANES: cover property (PLANE_WRITE_MASK == 4'hF);
endmodule
bind dgsr_top dgsr_checker chk_u (.CLK(CLK), .RST_N(RST_N), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
	.IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID),
	.HRETRACE(HRETRACE), .VRETRACE(VRETRACE), .CPU_WRITE(CPU_WRITE), .CPU_VRAM_ENABLE(CPU_VRAM_ENABLE),
	.IO_BASE_COLOUR(IO_BASE_COLOUR),
	.VCLK_USE_EXTENDED(VCLK_USE_EXTENDED), .SEQ_RESET(SEQ_RESET), .FONT_REGION(FONT_REGION),
	.CPU_MEM_FULL(CPU_MEM_FULL), .PLANE_WRITE_MASK(PLANE_WRITE_MASK));
`default_nettype wire

// [dgsr_host_model.sv]
// dgsr_host_model.sv: host cpu issuing io port reads and writes
// assumes requests taken on posedge CLK, read answer one cycle later
`timescale 1ns/1ps
`default_nettype none
module dgsr_host_model
(
	input  wire logic       CLK,
	input  wire logic [7:0] IO_RDATA,
	input  wire logic       IO_RVALID,
	output var  logic [9:0] IO_ADDR,
	output var  logic       IO_WR,
	output var  logic       IO_RD,
	output var  logic [7:0] IO_WDATA
);
initial
begin
	IO_ADDR = 10'h000;
	IO_WR = 1'b0;
	IO_RD = 1'b0;
	IO_WDATA = 8'h00;
end
// released lines show inverted values, never the last one
task wr(input logic [9:0] a, input logic [7:0] d);
	@(posedge CLK);
	#1;
	IO_ADDR = a;
	IO_WDATA = d;
	IO_WR = 1'b1;
	@(posedge CLK);
	#1;
	IO_WR = 1'b0;
	IO_ADDR = ~a;
	IO_WDATA = ~d;
endtask
task rd(input logic [9:0] a, output logic [7:0] d, output logic v);
	@(posedge CLK);
	#1;
	IO_ADDR = a;
	IO_RD = 1'b1;
	@(posedge CLK);
	#1;
	IO_RD = 1'b0;
	IO_ADDR = ~a;
	d = IO_RDATA;
	v = IO_RVALID;
endtask
task seq_wr(input logic [2:0] i, input logic [7:0] d);
	wr(10'h3C4, {5'h00, i});
	wr(10'h3C5, d);
endtask
endmodule
`default_nettype wire

// [dgsr_tb.sv]
// dgsr_tb.sv: self-checking testbench of the general and sequencer register bank
// assumes dgsr_top, its checker and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end
module tb;
logic       CLK, RST_N, IO_WR, IO_RD, IO_RVALID, hs, vs, hr, vr, vde, mon, ab3, cw, odd;
logic [9:0] IO_ADDR;
logic [7:0] IO_WDATA, IO_RDATA, col;
logic [1:0] fsel, alow, VCLK_SOURCE, SERIAL_LOAD_RATE;
logic       IO_BASE_COLOUR, CPU_VRAM_ENABLE, VCLK_USE_EXTENDED, PAGE_HIGH, HSYNC_OUT, VSYNC_OUT;
logic       SEQ_RESET, CHAR_8DOT, DOT_CLK_HALF, SCREEN_OFF, CPU_MEM_FULL;
logic [2:0] FONT_REGION;
logic [3:0] PLANE_WRITE_MASK;
int         num_errors, n_checks, cyc;
dgsr_top dut_u (.CLK(CLK), .RST_N(RST_N), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
	.IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID), .HSYNC_RAW(hs), .VSYNC_RAW(vs),
	.HRETRACE(hr), .VRETRACE(vr), .VDISP_EN(vde), .MON_SENSE(mon), .ATTR_COLOUR(col),
	.ATTR_FEEDBACK_SEL(fsel), .ATTR_BIT3(ab3), .CPU_WRITE(cw), .CPU_ODD(odd), .CPU_ADDR_LOW(alow),
	.IO_BASE_COLOUR(IO_BASE_COLOUR), .CPU_VRAM_ENABLE(CPU_VRAM_ENABLE), .VCLK_SOURCE(VCLK_SOURCE),
	.VCLK_USE_EXTENDED(VCLK_USE_EXTENDED), .PAGE_HIGH(PAGE_HIGH), .HSYNC_OUT(HSYNC_OUT),
	.VSYNC_OUT(VSYNC_OUT), .SEQ_RESET(SEQ_RESET), .CHAR_8DOT(CHAR_8DOT), .DOT_CLK_HALF(DOT_CLK_HALF),
	.SERIAL_LOAD_RATE(SERIAL_LOAD_RATE), .SCREEN_OFF(SCREEN_OFF), .FONT_REGION(FONT_REGION),
	.CPU_MEM_FULL(CPU_MEM_FULL), .PLANE_WRITE_MASK(PLANE_WRITE_MASK));
dgsr_host_model host_u (.CLK(CLK), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID), .IO_ADDR(IO_ADDR),
	.IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA));
// ****************************************
// clock, timeout and shared tasks
// ****************************************
initial
begin
	CLK = 1'b0;
	forever #10 CLK = ~CLK;
end
always @(posedge CLK)
begin
	cyc++;
	if (cyc == 5000)
	begin
		num_errors++;
		print_verdict;
	end
end
task print_verdict;
	$display("comparisons %0d mismatches %0d", n_checks, num_errors);
	if (num_errors == 0 && n_checks > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
task rchk(input logic [9:0] a, input logic [7:0] e, input logic ev);
	logic [7:0] d;
	logic       v;
	host_u.rd(a, d, v);
	`CHK("read data", e, d)
	`CHK("read valid", ev, v)
endtask
task settle;
	repeat (3) @(posedge CLK);
	#1;
endtask
task done(input string t);
	$display("test %s finished", t);
endtask
// ****************************************
// tests
// ****************************************
initial
begin
	{hs, vs, hr, vr, vde, mon, ab3, cw, odd, col, fsel, alow} = '0;
	RST_N = 1'b0;
	repeat (3) @(posedge CLK);
	#1 RST_N = 1'b1;
	rchk(10'h3CC, 8'h00, 1'b1);
	rchk(10'h3CA, 8'h00, 1'b1);
	`CHK("seq reset", 1'b1, SEQ_RESET)
	for (int i = 0; i < 5; i++)
	begin
		host_u.wr(10'h3C4, i[7:0]);
		rchk(10'h3C5, 8'h00, 1'b1);
	end
	done("reset");
	for (int c = 0; c < 4; c++)
	begin
		host_u.wr(10'h3C2, {4'h0, c[1:0], 2'b11});
		settle;
		`CHK("clock bits", c[1:0], VCLK_SOURCE)
		`CHK("clock ext", (c == 3), VCLK_USE_EXTENDED)
		`CHK("vram en", 1'b1, CPU_VRAM_ENABLE)
		`CHK("base", 1'b1, IO_BASE_COLOUR)
	end
	host_u.wr(10'h3C2, 8'hFF);
	rchk(10'h3CC, 8'hEF, 1'b1);
	{hs, vs} = 2'b11;
	settle;
	`CHK("page", 1'b1, PAGE_HIGH)
	`CHK("hsync neg", 1'b0, HSYNC_OUT)
	`CHK("vsync neg", 1'b0, VSYNC_OUT)
	host_u.wr(10'h3C2, 8'h03);
	settle;
	`CHK("hsync pos", 1'b1, HSYNC_OUT)
	`CHK("vsync pos", 1'b1, VSYNC_OUT)
	`CHK("page low", 1'b0, PAGE_HIGH)
	host_u.wr(10'h3DA, 8'hFF);
	rchk(10'h3CA, 8'h08, 1'b1);
	{vs, vde} = 2'b01;
	settle;
	`CHK("vsync or", 1'b1, VSYNC_OUT)
	vde = 1'b0;
	settle;
	`CHK("vsync or off", 1'b0, VSYNC_OUT)
	done("general output");
	{hr, mon, col, fsel} = {2'b11, 8'h20, 2'h1};
	rchk(10'h3DA, 8'h25, 1'b1);
	rchk(10'h3BA, 8'h00, 1'b0);
	rchk(10'h3C2, 8'h90, 1'b1);
	rchk(10'h3C0, 8'h00, 1'b0);
	vr = 1'b1;
	rchk(10'h3DA, 8'h2D, 1'b1);
	rchk(10'h3C2, 8'h10, 1'b1);
	host_u.wr(10'h3C2, 8'h02);
	rchk(10'h3BA, 8'h2D, 1'b1);
	{fsel, col} = {2'h3, 8'h40};
	rchk(10'h3BA, 8'h1D, 1'b1);
	{fsel, col} = {2'h2, 8'h08};
	rchk(10'h3BA, 8'h2D, 1'b1);
	{fsel, col} = {2'h0, 8'h01};
	rchk(10'h3BA, 8'h1D, 1'b1);
	rchk(10'h3DA, 8'h00, 1'b0);
	done("status");
	host_u.wr(10'h3C4, 8'hFF);
	rchk(10'h3C4, 8'h07, 1'b1);
	rchk(10'h3C5, 8'h00, 1'b1);
	host_u.seq_wr(3'h0, 8'hFF);
	rchk(10'h3C5, 8'h03, 1'b1);
	settle;
	`CHK("seq run", 1'b0, SEQ_RESET)
	host_u.seq_wr(3'h0, 8'h02);
	settle;
	`CHK("seq held", 1'b1, SEQ_RESET)
	host_u.seq_wr(3'h0, 8'h03);
	host_u.seq_wr(3'h1, 8'hFF);
	rchk(10'h3C5, 8'h3D, 1'b1);
	settle;
	`CHK("8 dot", 1'b1, CHAR_8DOT)
	`CHK("dot half", 1'b1, DOT_CLK_HALF)
	`CHK("load 4", 2'h2, SERIAL_LOAD_RATE)
	`CHK("screen off", 1'b1, SCREEN_OFF)
	host_u.seq_wr(3'h1, 8'h04);
	settle;
	`CHK("load 2", 2'h1, SERIAL_LOAD_RATE)
	`CHK("9 dot", 1'b0, CHAR_8DOT)
	`CHK("dot full", 1'b0, DOT_CLK_HALF)
	`CHK("screen on", 1'b0, SCREEN_OFF)
	host_u.seq_wr(3'h1, 8'h00);
	settle;
	`CHK("load 1", 2'h0, SERIAL_LOAD_RATE)
	done("sequencer");
	host_u.seq_wr(3'h2, 8'hFF);
	host_u.seq_wr(3'h4, 8'h08);
	cw = 1'b1;
	for (int a = 0; a < 4; a++)
	begin
		alow = a[1:0];
		settle;
		`CHK("chain4", 4'h1 << a, PLANE_WRITE_MASK)
	end
	host_u.seq_wr(3'h4, 8'h00);
	settle;
	`CHK("even", 4'h5, PLANE_WRITE_MASK)
	odd = 1'b1;
	settle;
	`CHK("odd", 4'hA, PLANE_WRITE_MASK)
	host_u.seq_wr(3'h4, 8'h04);
	settle;
	`CHK("sequential", 4'hF, PLANE_WRITE_MASK)
	host_u.seq_wr(3'h2, 8'h03);
	settle;
	`CHK("plane enables", 4'h3, PLANE_WRITE_MASK)
	host_u.wr(10'h3C2, 8'h00);
	settle;
	`CHK("vram off", 4'h0, PLANE_WRITE_MASK)
	cw = 1'b0;
	done("planes");
	host_u.seq_wr(3'h3, 8'h12);
	ab3 = 1'b1;
	settle;
	`CHK("font limited", 3'h1, FONT_REGION)
	`CHK("limited mem", 1'b0, CPU_MEM_FULL)
	host_u.seq_wr(3'h4, 8'h02);
	settle;
	`CHK("full mem", 1'b1, CPU_MEM_FULL)
	`CHK("font b", 3'h5, FONT_REGION)
	ab3 = 1'b0;
	settle;
	`CHK("font a", 3'h0, FONT_REGION)
	ab3 = 1'b1;
	host_u.seq_wr(3'h0, 8'h01);
	settle;
	`CHK("font cleared", 3'h0, FONT_REGION)
	RST_N = 1'b0;
	@(posedge CLK);
	#1 RST_N = 1'b1;
	rchk(10'h3CC, 8'h00, 1'b1);
	done("font and reset");
	print_verdict;
end
endmodule
`default_nettype wire
